//--- rtl/dssr_top.sv
// Overview of operation
// - Two independent registers, 512 or 480 bits
// - Shift one position on clock falling edge
// - Select 0 recirculates, 1 writes input
// - Master follows input high, slave loads low
// - Contents kept while clock low; high limited
`timescale 1ns/1ps
module dssr_top #(
  parameter int REG_LEN = dssr_pkg::LONG_LEN,
  parameter bit FAST_GRADE = 1'b1,
  parameter int HIGH_MAX_CYC = dssr_pkg::CLK_HIGH_MAX_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic mode_select,
  input wire logic serial_in_first,
  input wire logic serial_in_second,
  output logic serial_out_first,
  output logic serial_out_second,
  output logic clk_high_overrun,
  output logic clk_rate_violation
);

  localparam int HW = $clog2(HIGH_MAX_CYC + 1);
  localparam int MIN_PER = FAST_GRADE ? dssr_pkg::FAST_MIN_PERIOD_CYC : dssr_pkg::STD_MIN_PERIOD_CYC;
  localparam logic [HW-1:0] HIGH_LIMIT = HW'(HIGH_MAX_CYC);
  localparam logic [dssr_pkg::GAP_W-1:0] GAP_MIN = dssr_pkg::GAP_W'(MIN_PER);
  localparam logic [dssr_pkg::GAP_W-1:0] GAP_SAT = '1;

  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_d;
    dssr_pkg::dssr_pins_type pin_s1;
    dssr_pkg::dssr_pins_type pin_s2;
    dssr_pkg::dssr_pins_type master;
    logic shift;
    logic [HW-1:0] high_cnt;
    logic overrun;
    logic [dssr_pkg::GAP_W-1:0] gap_cnt;
    logic seen_fall;
    logic rate_err;
  } dssr_state_type;

  dssr_state_type st_r;
  dssr_state_type st_nxt;
  dssr_pkg::dssr_pins_type pins_in;
  logic fall;

  assign pins_in = '{mode_select: mode_select, serial_in_first: serial_in_first,
                     serial_in_second: serial_in_second};
  assign fall = st_r.clk_d & ~st_r.clk_s2;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Pins pass two flops; clock and data share the same delay
    st_nxt.clk_s1 = shift_clk;
    st_nxt.clk_s2 = st_r.clk_s1;
    st_nxt.clk_d = st_r.clk_s2;
    st_nxt.pin_s1 = pins_in;
    st_nxt.pin_s2 = st_r.pin_s1;
    // Master transparent while clock high, frozen while low
    if (st_r.clk_s2) begin
      st_nxt.master = st_r.pin_s2;
    end
    // Slave chain advances once per falling edge
    st_nxt.shift = fall;
    // Clock high time monitor
    if (!st_r.clk_s2) begin
      st_nxt.high_cnt = '0;
      st_nxt.overrun = 1'b0;
    end else if (st_r.high_cnt != HIGH_LIMIT) begin
      st_nxt.high_cnt = st_r.high_cnt + HW'(1);
    end else begin
      st_nxt.overrun = 1'b1;
    end
    // Falling edge spacing against the grade limit
    if (fall) begin
      st_nxt.gap_cnt = dssr_pkg::GAP_W'(1);
      st_nxt.seen_fall = 1'b1;
      if (st_r.seen_fall && st_r.gap_cnt < GAP_MIN) begin
        st_nxt.rate_err = 1'b1;
      end
    end else if (st_r.gap_cnt != GAP_SAT) begin
      st_nxt.gap_cnt = st_r.gap_cnt + dssr_pkg::GAP_W'(1);
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{clk_s1: 1'b0, clk_s2: 1'b0, clk_d: 1'b0, pin_s1: dssr_pkg::PINS_RST,
                pin_s2: dssr_pkg::PINS_RST, master: dssr_pkg::PINS_RST, shift: 1'b0,
                high_cnt: '0, overrun: 1'b0, gap_cnt: '0, seen_fall: 1'b0, rate_err: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clk_high_overrun = st_r.overrun;
  assign clk_rate_violation = st_r.rate_err;

  // ------------------------------------------------------------
  // Two independent storage lanes
  // ------------------------------------------------------------
  dssr_lane #(.LEN(REG_LEN)) u_lane_first (
    .clk(clk),
    .rst_n(rst_n),
    .shift(st_r.shift),
    .write_sel(st_r.master.mode_select),
    .write_bit(st_r.master.serial_in_first),
    .serial_out(serial_out_first)
  );

  dssr_lane #(.LEN(REG_LEN)) u_lane_second (
    .clk(clk),
    .rst_n(rst_n),
    .shift(st_r.shift),
    .write_sel(st_r.master.mode_select),
    .write_bit(st_r.master.serial_in_second),
    .serial_out(serial_out_second)
  );

endmodule

//--- rtl/dssr_pkg.sv
package dssr_pkg;

  // ------------------------------------------------------------
  // Register lengths
  // ------------------------------------------------------------
  localparam int LONG_LEN = 512;
  localparam int SHORT_LEN = 480;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CLK_HIGH_MAX_US = 100;
  localparam int CLK_HIGH_MAX_CYC = (CLK_HIGH_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int FAST_MAX_KHZ = 3000;
  localparam int STD_MAX_KHZ = 1500;
  localparam int FAST_MIN_PERIOD_CYC = (1000000000 / FAST_MAX_KHZ + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STD_MIN_PERIOD_CYC = (1000000000 / STD_MAX_KHZ + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GAP_W = 8;

  // ------------------------------------------------------------
  // Pin group sampled with the shift clock
  // ------------------------------------------------------------
  typedef struct packed {
    logic mode_select;
    logic serial_in_first;
    logic serial_in_second;
  } dssr_pins_type;

  localparam dssr_pins_type PINS_RST = '{mode_select: 1'b0, serial_in_first: 1'b0, serial_in_second: 1'b0};

endpackage

//--- rtl/dssr_lane.sv
`timescale 1ns/1ps
module dssr_lane #(
  parameter int LEN = dssr_pkg::LONG_LEN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic shift,
  input wire logic write_sel,
  input wire logic write_bit,
  output logic serial_out
);

  typedef struct packed {
    logic [LEN-1:0] cells;
  } dssr_lane_type;

  dssr_lane_type st_r;
  dssr_lane_type st_nxt;

  // ------------------------------------------------------------
  // Storage chain
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (shift) begin
      st_nxt.cells = {st_r.cells[LEN-2:0], write_sel ? write_bit : st_r.cells[LEN-1]};
    end
  end

  // Holds indefinitely when no shift arrives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign serial_out = st_r.cells[LEN-1];

endmodule

//--- dv/dssr_top_monitor.sv
`timescale 1ns/1ps
module dssr_top_monitor #(parameter int HIGH_MAX_CYC = dssr_pkg::CLK_HIGH_MAX_CYC) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic mode_select,
  input wire logic serial_in_first,
  input wire logic serial_in_second,
  input wire logic serial_out_first,
  input wire logic serial_out_second,
  input wire logic clk_high_overrun,
  input wire logic clk_rate_violation
);
  logic [15:0] hi_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_r <= 16'h0000;
    end else begin
      hi_r <= shift_clk ? hi_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence low_run;
    !shift_clk [*4];
  endsequence
  chk_out1_moves: assert property ($changed(serial_out_first) |-> $past(shift_clk, 6) && !$past(shift_clk, 3))
    else $error("first output moved without a fall");
  chk_out2_moves: assert property ($changed(serial_out_second) |-> $past(shift_clk, 6) && !$past(shift_clk, 3))
    else $error("second output moved without a fall");
  chk_low_hold: assert property (!shift_clk [*8] |-> $stable(serial_out_first) && $stable(serial_out_second))
    else $error("output changed while clock low");
  chk_ovr_early: assert property ($rose(clk_high_overrun) |-> hi_r >= HIGH_MAX_CYC)
    else $error("overrun flagged too early");
  chk_ovr_late: assert property (hi_r == HIGH_MAX_CYC + 6 |-> clk_high_overrun)
    else $error("overrun not flagged");
  chk_ovr_clear: assert property (low_run |=> !clk_high_overrun)
    else $error("overrun not cleared");
  chk_rate_sticky: assert property (clk_rate_violation |=> clk_rate_violation)
    else $error("rate flag dropped");
endmodule
bind dssr_top dssr_top_monitor #(.HIGH_MAX_CYC(HIGH_MAX_CYC)) u_mon (.clk(clk), .rst_n(rst_n),
  .shift_clk(shift_clk), .mode_select(mode_select), .serial_in_first(serial_in_first),
  .serial_in_second(serial_in_second), .serial_out_first(serial_out_first), .serial_out_second(serial_out_second),
  .clk_high_overrun(clk_high_overrun), .clk_rate_violation(clk_rate_violation));

//--- dv/dssr_ctrl.sv
`timescale 1ns/1ps
module dssr_ctrl (
  input wire logic clk,
  output logic shift_clk,
  output logic mode_select,
  output logic serial_in_first,
  output logic serial_in_second
);
  initial begin
    {shift_clk, mode_select, serial_in_first, serial_in_second} = 4'h0;
  end
  // One period: pins set while low, held well past the fall
  task automatic pulse(input logic s, input logic a, input logic b, input int hi, input int lo);
    @(negedge clk);
    mode_select = s;
    serial_in_first = a;
    serial_in_second = b;
    @(negedge clk);
    shift_clk = 1'b1;
    repeat (hi) @(negedge clk);
    shift_clk = 1'b0;
    repeat (lo) @(negedge clk);
  endtask
  // Write period whose data turns right only halfway through the high phase
  task automatic pulse_mid(input logic a, input logic b, input int hi, input int lo);
    @(negedge clk);
    mode_select = 1'b1;
    serial_in_first = ~a;
    serial_in_second = ~b;
    @(negedge clk);
    shift_clk = 1'b1;
    repeat (hi / 2) @(negedge clk);
    serial_in_first = a;
    serial_in_second = b;
    repeat (hi - hi / 2) @(negedge clk);
    shift_clk = 1'b0;
    repeat (lo) @(negedge clk);
  endtask
endmodule

//--- dv/dual_static_recirc_shift_register_tb.sv
`timescale 1ns/1ps
module dual_static_recirc_shift_register_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic shift_clk, mode_select, serial_in_first, serial_in_second, o1, o2, ovr, rate;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  dssr_ctrl u_ctrl (.clk(clk), .shift_clk(shift_clk), .mode_select(mode_select),
    .serial_in_first(serial_in_first), .serial_in_second(serial_in_second));
  dssr_top #(.REG_LEN(480), .FAST_GRADE(1'b1), .HIGH_MAX_CYC(50)) dut (.clk(clk), .rst_n(rst_n),
    .shift_clk(shift_clk), .mode_select(mode_select), .serial_in_first(serial_in_first),
    .serial_in_second(serial_in_second), .serial_out_first(o1), .serial_out_second(o2),
    .clk_high_overrun(ovr), .clk_rate_violation(rate));
  task automatic chk(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %b got %b", what, exp, got);
    end
  endtask
  function automatic logic pat(input int k);
    return k[0] ^ k[2] ^ k[5];
  endfunction
  task automatic test_done;
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic t_write_read;
    for (int k = 0; k < 480; k++) u_ctrl.pulse_mid(pat(k), ~pat(k), 34, 34);
    repeat (300) @(negedge clk);
    for (int k = 0; k < 480; k++) begin
      chk("out1", pat(k), o1);
      chk("out2", ~pat(k), o2);
      u_ctrl.pulse(1'b0, ~pat(k), pat(k), 34, 34);
    end
    chk("out1", pat(0), o1);
    chk("rate", 1'b0, rate);
    $display("write_read done");
  endtask
  task automatic t_overrun;
    fork
      u_ctrl.pulse(1'b0, 1'b0, 1'b0, 80, 34);
      begin
        repeat (72) @(negedge clk);
        chk("overrun", 1'b1, ovr);
      end
    join
    chk("overrun", 1'b0, ovr);
    u_ctrl.pulse(1'b0, 1'b0, 1'b0, 4, 4);
    u_ctrl.pulse(1'b0, 1'b0, 1'b0, 4, 4);
    chk("rate", 1'b1, rate);
    $display("overrun_rate done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("out1", 1'b0, o1);
    t_write_read();
    t_overrun();
    test_done();
  end
endmodule
